// ===== core/mcsd_area_match.sv
`include "mcsd_cfg.svh"
// Masked compare of address lines 23..12 against a reference pattern
module mcsd_area_match (
  // Address and compare settings
  input  wire logic [31:0] addr,
  input  wire logic [11:0] mask,
  input  wire logic [11:0] pattern,
  // Result
  output logic             hit
);
  // Top byte must be zero; masked bits must equal pattern
  assign hit = (addr[31:24] == 8'h00) &&
               (((addr[23:12] ^ pattern) & mask) == 12'h000);
endmodule // mcsd_area_match

// ===== core/mcsd_mid_split.sv
`include "mcsd_cfg.svh"
// Picks the quarter of the mid-range area from the top two unmasked lines below the mask
module mcsd_mid_split (
  // Area settings
  input  wire logic [31:0] addr,
  input  wire logic [9:0]  mask,
  // Quarter index
  output logic [1:0]       quarter
);
  logic [9:0] freeBits;
  assign freeBits = ~mask;

  // Quarter bits are the two highest don't-care lines 23..14 below a mask run
  // An all-free run starts at A23; otherwise the top of the free run sits below a mask bit
  always_comb begin
    quarter = addr[15:14];
    if (freeBits[9]) quarter = addr[23:22];
    for (int i = 8; i >= 1; i--) begin
      if (freeBits[i] && !freeBits[i+1]) begin
        quarter = {addr[i+14], addr[i+13]};
      end
    end
  end
endmodule // mcsd_mid_split

// ===== core/mcsd_select_decode.sv
`include "mcsd_cfg.svh"
// Behaviour
// - Lower area starts at zero, power-of-two size from 4 Kbytes via mask.
// - Lower mask bit set forces address line 23..12 to zero; clear ignores it.
// - Lower select needs master enable, A31-A24 zero, masked lines zero.
// - Lower refresh enable asserts lower select in refresh, ignoring master enable.
// - Upper area sits just below the 16 Mbyte top, power-of-two size.
// - Upper mask bit set forces address line 23..12 to one; clear ignores it.
// - Upper select needs master enable, A31-A24 zero, masked lines one.
// - Upper refresh enable asserts upper select in refresh, ignoring master enable.
// - Scheme 1 splits mid area into four quarters, select 0 lowest.
// - Scheme 2 mid area lies between lower and upper areas.
// - Scheme 1 mid mask bit set compares address line with base bit.
// - Scheme 2 ignores the mid mask bits.
// - Each mid select has its own refresh enable.
// - Reserved register bits read zero; software writes zero.
// - Scheme 2 uses only mid select 0 for the whole mid area.
// - Scheme 1 mid select needs enable, A31-A24 zero, masked base match.
// - Enabled select asserts one clock after its transaction starts, from the second clock on.
module mcsd_select_decode (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Memory bus transaction
  input  wire logic [31:0]          memAddr,
  input  wire logic                 memStart,
  input  wire logic                 memActive,
  input  wire logic                 refreshActive,
  // Chip selects
  output mcsd_pkg::mcsd_sel_type    selectN
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mcsd_pkg::mcsd_cfg_type cfg;
    mcsd_pkg::mcsd_bus_type bus;
    mcsd_pkg::mcsd_sel_type sel;
  } mcsd_state_type;

  mcsd_state_type state;
  mcsd_state_type next_state;

  // ----------------------------------------------------------------
  // Area matching
  // ----------------------------------------------------------------
  logic       lowerHit;
  logic       upperHit;
  logic       midHit;
  logic [1:0] quarter;
  logic       inLower;
  logic       inUpper;
  logic       topZero;

  // Lower area compares masked lines against zero
  mcsd_area_match lowerMatch (
    .addr    (memAddr),
    .mask    (state.cfg.lowerMask),
    .pattern (12'h000),
    .hit     (lowerHit)
  );

  // Upper area compares masked lines against one
  mcsd_area_match upperMatch (
    .addr    (memAddr),
    .mask    (state.cfg.upperMask),
    .pattern (12'hFFF),
    .hit     (upperHit)
  );

  // Mid area compares masked lines against the base
  mcsd_area_match midMatch (
    .addr    (memAddr),
    .mask    ({state.cfg.midMask, 2'b00}),
    .pattern ({state.cfg.midBase, 2'b00}),
    .hit     (midHit)
  );

  // Quarter index from the first free lines below the mask run
  mcsd_mid_split midSplit (
    .addr    (memAddr),
    .mask    (state.cfg.midMask),
    .quarter (quarter)
  );

  // Scheme 2 range membership is taken from the areas alone, not enables
  assign inLower = lowerHit;
  assign inUpper = upperHit;
  assign topZero = (memAddr[31:24] == 8'h00);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       memCycle;
    logic [7:0] wbyte;
    logic [7:0] a;
    next_state = state;
    memCycle   = memStart || memActive;
    wbyte      = hwdata[7:0];
    a          = state.bus.addr;

    // Selects follow the current address; evaluated every cycle
    next_state.sel = '{lowerN: 1'b1, upperN: 1'b1, midN: 4'hF};
    if (memCycle && !refreshActive) begin
      if (state.cfg.lowerEnable && lowerHit) next_state.sel.lowerN = 1'b0;
      if (state.cfg.upperEnable && upperHit) next_state.sel.upperN = 1'b0;
      if (state.cfg.quarterEnable && midHit) begin
        next_state.sel.midN[quarter] = 1'b0;
      end else if (state.cfg.singleEnable && topZero && !inLower && !inUpper) begin
        next_state.sel.midN[0] = 1'b0;
      end
    end
    if (memCycle && refreshActive) begin
      next_state.sel.lowerN = ~state.cfg.lowerRefresh;
      next_state.sel.upperN = ~state.cfg.upperRefresh;
      next_state.sel.midN   = ~state.cfg.midRefresh;
    end

    // Address phase capture
    next_state.bus.pending = 1'b0;
    if (hsel && hready && (htrans == `MCSD_HTRANS_NONSEQ || htrans == `MCSD_HTRANS_SEQ)) begin
      next_state.bus.pending = 1'b1;
      next_state.bus.write   = hwrite;
      next_state.bus.addr    = haddr[7:0];
    end

    // Data phase write; reserved bits are not stored
    if (state.bus.pending && state.bus.write) begin
      unique case (a)
        `MCSD_OFS_LMASK_LO: begin
          next_state.cfg.lowerMask[3:0] = wbyte[7:4];
          next_state.cfg.lowerRefresh   = wbyte[0];
        end
        `MCSD_OFS_LMASK_HI: next_state.cfg.lowerMask[11:4] = wbyte;
        `MCSD_OFS_UMASK_LO: begin
          next_state.cfg.upperMask[3:0] = wbyte[7:4];
          next_state.cfg.upperRefresh   = wbyte[0];
        end
        `MCSD_OFS_UMASK_HI: next_state.cfg.upperMask[11:4] = wbyte;
        `MCSD_OFS_MMASK_LO: begin
          next_state.cfg.midMask[1:0] = wbyte[7:6];
          next_state.cfg.midRefresh   = wbyte[3:0];
        end
        `MCSD_OFS_MMASK_HI: next_state.cfg.midMask[9:2] = wbyte;
        `MCSD_OFS_MBASE_LO: next_state.cfg.midBase[1:0] = wbyte[7:6];
        `MCSD_OFS_MBASE_HI: next_state.cfg.midBase[9:2] = wbyte;
        `MCSD_OFS_ENABLE: begin
          // Set/reset write: only selected bits change
          if (wbyte[`MCSD_EN_LOWER_BIT]) next_state.cfg.lowerEnable = wbyte[`MCSD_EN_SR_BIT];
          if (wbyte[`MCSD_EN_UPPER_BIT]) next_state.cfg.upperEnable = wbyte[`MCSD_EN_SR_BIT];
          if (wbyte[`MCSD_EN_Q_BIT]) next_state.cfg.quarterEnable = wbyte[`MCSD_EN_SR_BIT];
          if (wbyte[`MCSD_EN_S_BIT]) next_state.cfg.singleEnable = wbyte[`MCSD_EN_SR_BIT];
        end
        default: ;
      endcase
    end

    // Read data prepared in the address phase, presented next cycle
    next_state.bus.rdata = `MCSD_RDATA_ZERO;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `MCSD_OFS_LMASK_LO: next_state.bus.rdata[7:0] =
          {state.cfg.lowerMask[3:0], 3'b000, state.cfg.lowerRefresh};
        `MCSD_OFS_LMASK_HI: next_state.bus.rdata[7:0] = state.cfg.lowerMask[11:4];
        `MCSD_OFS_UMASK_LO: next_state.bus.rdata[7:0] =
          {state.cfg.upperMask[3:0], 3'b000, state.cfg.upperRefresh};
        `MCSD_OFS_UMASK_HI: next_state.bus.rdata[7:0] = state.cfg.upperMask[11:4];
        `MCSD_OFS_MMASK_LO: next_state.bus.rdata[7:0] =
          {state.cfg.midMask[1:0], 2'b00, state.cfg.midRefresh};
        `MCSD_OFS_MMASK_HI: next_state.bus.rdata[7:0] = state.cfg.midMask[9:2];
        `MCSD_OFS_MBASE_LO: next_state.bus.rdata[7:0] = {state.cfg.midBase[1:0], 6'h00};
        `MCSD_OFS_MBASE_HI: next_state.bus.rdata[7:0] = state.cfg.midBase[9:2];
        `MCSD_OFS_ENABLE: next_state.bus.rdata[7:0] = {state.cfg.lowerEnable,
          state.cfg.upperEnable, state.cfg.quarterEnable, state.cfg.singleEnable, 4'h0};
        `MCSD_OFS_STATUS: next_state.bus.rdata[7:0] = {2'b00, state.sel};
        default: next_state.bus.rdata = `MCSD_RDATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves all selects high and every area disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= '0;
      state.sel <= '{lowerN: 1'b1, upperN: 1'b1, midN: 4'hF};
    end else begin
      state <= next_state;
    end
  end

  // Zero-wait slave, always OKAY
  assign hrdata    = state.bus.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign selectN   = state.sel;
endmodule // mcsd_select_decode

// ===== include/mcsd_cfg.svh
`ifndef MCSD_CFG_SVH
`define MCSD_CFG_SVH
// Register byte offsets (one aligned word each)
`define MCSD_OFS_LMASK_LO  8'h00
`define MCSD_OFS_LMASK_HI  8'h04
`define MCSD_OFS_UMASK_LO  8'h08
`define MCSD_OFS_UMASK_HI  8'h0C
`define MCSD_OFS_MMASK_LO  8'h10
`define MCSD_OFS_MMASK_HI  8'h14
`define MCSD_OFS_MBASE_LO  8'h18
`define MCSD_OFS_MBASE_HI  8'h1C
`define MCSD_OFS_ENABLE    8'h20
`define MCSD_OFS_STATUS    8'h24
// Field layouts
`define MCSD_LOW_MASK_MSK  8'hF1
`define MCSD_MID_MASK_MSK  8'hCF
`define MCSD_BASE_LO_MSK   8'hC0
`define MCSD_EN_MSK        8'hF0
`define MCSD_EN_SR_BIT     0
`define MCSD_EN_LOWER_BIT  7
`define MCSD_EN_UPPER_BIT  6
`define MCSD_EN_Q_BIT      5
`define MCSD_EN_S_BIT      4
`define MCSD_RESET_VALUE   8'h00
// AHB encodings
`define MCSD_HTRANS_NONSEQ 2'h2
`define MCSD_HTRANS_SEQ    2'h3
`define MCSD_RDATA_ZERO    32'h0000_0000
`endif

// ===== include/mcsd_pkg.sv
package mcsd_pkg;
  // Software-visible configuration
  typedef struct packed {
    logic [11:0] lowerMask;
    logic        lowerRefresh;
    logic [11:0] upperMask;
    logic        upperRefresh;
    logic [9:0]  midMask;
    logic [3:0]  midRefresh;
    logic [9:0]  midBase;
    logic        lowerEnable;
    logic        upperEnable;
    logic        quarterEnable;
    logic        singleEnable;
  } mcsd_cfg_type;

  // Selects, active low: lower, upper, four mid
  typedef struct packed {
    logic       lowerN;
    logic       upperN;
    logic [3:0] midN;
  } mcsd_sel_type;

  // Bus slave state
  typedef struct packed {
    logic       pending;
    logic       write;
    logic [7:0] addr;
    logic [31:0] rdata;
  } mcsd_bus_type;
endpackage

// ===== verif/mcsd_mem_model.sv
module mcsd_mem_model (
  // Clock and selects
  input wire logic                   clk,
  input wire mcsd_pkg::mcsd_sel_type selectN,
  // Selected cycles seen
  output int                         hits
);
  timeunit 1ns;
  timeprecision 1ps;
  int count = 0;

  // Counts cycles with any device selected; no data path is modelled
  assign hits = count;
  always @(posedge clk) begin
    if (selectN != 6'h3F) count <= count + 1;
  end
endmodule // mcsd_mem_model

// ===== verif/mcsd_select_checker.sv
module mcsd_select_checker (
  // Clock, reset and register bus
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // Memory transaction and selects
  input wire logic [31:0]           memAddr,
  input wire logic                  memStart,
  input wire logic                  memActive,
  input wire logic                  refreshActive,
  input wire mcsd_pkg::mcsd_sel_type selectN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read address phase and live transaction
  logic rd;
  logic tx;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign tx = memStart || memActive;
  property p_reset; $fell(rst) |-> selectN == 6'h3F; endproperty
  a_reset: assert property (p_reset) else $error("selects active after reset");
  property p_idle; !tx |=> selectN == 6'h3F; endproperty
  a_idle: assert property (p_idle) else $error("select active outside transaction");
  property p_top; tx && memAddr[31:24] != 8'h00 && !refreshActive |=> selectN == 6'h3F;
  endproperty
  a_top: assert property (p_top) else $error("select active above 16 Mbytes");
  property p_onemid; tx && !refreshActive |=> $onehot0(~selectN.midN); endproperty
  a_onemid: assert property (p_onemid) else $error("two mid selects active");
  property p_rsv_low; rd && (haddr[7:0] == 8'h00 || haddr[7:0] == 8'h08) |=> hrdata[3:1] == 3'h0;
  endproperty
  a_rsv_low: assert property (p_rsv_low) else $error("reserved bits 3-1 not zero");
  property p_rsv_mid; rd && haddr[7:0] == 8'h10 |=> hrdata[5:4] == 2'h0; endproperty
  a_rsv_mid: assert property (p_rsv_mid) else $error("reserved bits 5-4 not zero");
  property p_sr; rd && haddr[7:0] == 8'h20 |=> hrdata[3:0] == 4'h0; endproperty
  a_sr: assert property (p_sr) else $error("enable low bits not zero");
  property p_unmapped; rd && haddr[7:0] > 8'h27 |=> hrdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  // Main scenarios reached
  c_lower: cover property (tx ##1 !selectN.lowerN);
  c_mid3: cover property (tx ##1 !selectN.midN[3]);
  c_refresh: cover property (refreshActive ##1 selectN.midN == 4'hA);
endmodule // mcsd_select_checker

bind mcsd_select_decode mcsd_select_checker mcsd_select_checker_i (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .memAddr(memAddr), .memStart(memStart), .memActive(memActive),
  .refreshActive(refreshActive), .selectN(selectN));

// ===== verif/tb_memory_chip_select_decode.sv
module tb_memory_chip_select_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, memStart, memActive, refreshActive;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, memAddr, hrdata;
  logic        hreadyout, hresp;
  mcsd_pkg::mcsd_sel_type selectN;
  int          n_fail = 0, checks = 0, hits;

  // Bus ready loops back from the only slave
  mcsd_select_decode mcsd_select_decode_i (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .memAddr(memAddr), .memStart(memStart), .memActive(memActive),
    .refreshActive(refreshActive), .selectN(selectN));
  mcsd_mem_model mcsd_mem_model_i (.clk(clk), .selectN(selectN), .hits(hits));

  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task results;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One single word transfer; entered and left on a rising edge
  task bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rdchk(logic [7:0] a, logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("register", r, exp);
  endtask

  // Transaction of start plus two active cycles; selects must release after it
  task mem(logic [31:0] a, logic rf, logic [5:0] exp);
    memStart <= 1'b1; memAddr <= a; refreshActive <= rf;
    @(posedge clk);
    memStart <= 1'b0; memActive <= 1'b1;
    @(posedge clk);
    #1 chk("select", {26'h0, selectN}, {26'h0, exp});
    @(posedge clk);
    memActive <= 1'b0; refreshActive <= 1'b0; memAddr <= ~a;
    repeat (2) @(posedge clk);
    #1 chk("idle", {26'h0, selectN}, 32'h3F);
    @(posedge clk);
  endtask

  task t_regs;
    for (int i = 0; i < 9; i++) rdchk(8'(i * 4), 32'h0);
    rdchk(8'h24, 32'h3F);
    wr(8'h40, 32'hFF);
    rdchk(8'h40, 32'h0);
    wr(8'h00, 32'hFF);
    rdchk(8'h00, 32'hF1);
    wr(8'h10, 32'hFF);
    rdchk(8'h10, 32'hCF);
    wr(8'h10, 32'h00);
  endtask
  task t_lower;
    wr(8'h00, 32'hF0);
    wr(8'h04, 32'hFF);
    wr(8'h20, 32'h81);
    rdchk(8'h20, 32'h80);
    mem(32'h0000_0FFC, 1'b0, 6'h1F);
    mem(32'h0000_1000, 1'b0, 6'h3F);
    mem(32'h0100_0000, 1'b0, 6'h3F);
  endtask
  task t_refresh;
    wr(8'h20, 32'h80);
    wr(8'h00, 32'hF1);
    wr(8'h10, 32'h05);
    wr(8'h08, 32'h01);
    mem(32'h0000_0000, 1'b0, 6'h3F);
    mem(32'h0012_3456, 1'b1, 6'h0A);
    wr(8'h00, 32'hF0);
    wr(8'h10, 32'h00);
  endtask
  task t_upper;
    wr(8'h08, 32'hE0);
    wr(8'h0C, 32'hFF);
    wr(8'h20, 32'h41);
    mem(32'h00FF_E000, 1'b0, 6'h2F);
    mem(32'h00FF_DFFF, 1'b0, 6'h3F);
  endtask
  task t_quarter;
    wr(8'h14, 32'hF0);
    wr(8'h1C, 32'h30);
    wr(8'h20, 32'h21);
    for (int q = 0; q < 4; q++) mem(32'h30_0000 + (q << 18), 1'b0, {2'b11, ~(4'h1 << q)});
    mem(32'h0040_0000, 1'b0, 6'h3F);
  endtask
  task t_single;
    wr(8'h20, 32'h20);
    wr(8'h20, 32'h91);
    mem(32'h0050_0000, 1'b0, 6'h3E);
    mem(32'h0000_0100, 1'b0, 6'h1F);
    mem(32'h00FF_F000, 1'b0, 6'h2F);
    wr(8'h14, 32'h00);
    mem(32'h0070_0000, 1'b0, 6'h3E);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // About 180 cycles of work; 5000 leaves ample margin
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    memStart = 1'b0; memActive = 1'b0; refreshActive = 1'b0; memAddr = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_lower();
    t_refresh();
    t_upper();
    t_quarter();
    t_single();
    chk("model", 32'(hits > 0), 32'h1);
    results();
  end
endmodule // tb_memory_chip_select_decode
